// File: hw/casbe_exec.sv
// execution unit for decrement, increment, skip, clear, or-literal and branch
`timescale 1ns/10ps
module casbe_exec
  import casbe_pkg::*;
(
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // instruction hand-off
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR,
  output logic INSTR_READY,
  output logic INSTR_DONE,
  output logic INSTR_DISCARDED,
  // program counter upper latch
  input wire logic [LATCH_W-1:0] PC_UPPER_LATCH,
  // file register preload
  input wire logic LOAD_WR_EN,
  input wire logic [FILE_AW-1:0] LOAD_WR_ADDR,
  input wire logic [DATA_W-1:0] LOAD_WR_DATA,
  // architectural state
  output logic [DATA_W-1:0] WORKING,
  output logic ZERO_FLAG,
  output logic [PC_W-1:0] PC,
  // file write-back trace
  output logic FILE_WR_EN,
  output logic [FILE_AW-1:0] FILE_WR_ADDR,
  output logic [DATA_W-1:0] FILE_WR_DATA
);

  casbe_state_e state_q, state_d;
  logic [INSTR_W-1:0] instr_q;
  logic skip_q, skip_d;
  logic [DATA_W-1:0] w_q, w_d;
  logic z_q, z_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic ready_q;
  logic done_q;
  logic disc_q;
  logic fwe_q;
  logic [FILE_AW-1:0] fwa_q;
  logic [DATA_W-1:0] fwd_q;

  // handshake and phase
  wire in_idle = (state_q == ST_IDLE);
  wire in_exec = (state_q == ST_EXEC);
  wire accept = in_idle && INSTR_VALID;
  wire load_ok = in_idle && LOAD_WR_EN;
  // a discarded follower still spends its cycle, it just has no effect
  wire live = in_exec && !skip_q;

  // decode
  wire is_decrement_file = (instr_q & MASK_FILE_OP) == OPC_DECREMENT_FILE;
  wire is_increment_file = (instr_q & MASK_FILE_OP) == OPC_INCREMENT_FILE;
  wire is_decsz = (instr_q & MASK_FILE_OP) == OPC_DECREMENT_SKIP_ZERO;
  wire is_incsz = (instr_q & MASK_FILE_OP) == OPC_INCREMENT_SKIP_ZERO;
  wire is_clear_working = (instr_q & MASK_CLEAR_W) == OPC_CLEAR_WORKING;
  wire is_unconditional_branch = (instr_q & MASK_BRANCH) == OPC_UNCONDITIONAL_BRANCH;
  wire is_or_literal_working = (instr_q & MASK_LITERAL) == OPC_OR_LITERAL_WORKING;
  wire is_dec = is_decrement_file || is_decsz;
  wire is_file_op = is_dec || is_increment_file || is_incsz;
  wire is_skip_op = is_decsz || is_incsz;

  // operand fields
  wire [FILE_AW-1:0] f_addr = instr_q[FILE_ADDR_HI:FILE_ADDR_LO];
  wire dest_sel = instr_q[DEST_BIT];
  wire [FILE_AW-1:0] rd_addr = INSTR[FILE_ADDR_HI:FILE_ADDR_LO];
  wire [DATA_W-1:0] literal = instr_q[LIT_HI:LIT_LO];
  wire [BR_W-1:0] br_target = instr_q[BR_HI:BR_LO];

  // datapath
  logic [DATA_W-1:0] rd_data;
  wire [DATA_W-1:0] dec_val = rd_data - DATA_ONE;
  wire [DATA_W-1:0] inc_val = rd_data + DATA_ONE;
  wire [DATA_W-1:0] file_res = is_dec ? dec_val : inc_val;
  wire [DATA_W-1:0] or_val = w_q | literal;
  wire file_res_zero = (file_res == DATA_ZERO);
  wire or_zero = (or_val == DATA_ZERO);

  // destination steering
  wire wr_file = live && is_file_op && (dest_sel == DEST_FILE);
  wire wr_w_file = live && is_file_op && (dest_sel == DEST_WORKING);
  wire take_skip = live && is_skip_op && file_res_zero;
  wire take_unconditional_branch = live && is_unconditional_branch;

  // file write port: preload only while idle, so it never meets write-back
  wire mem_we = wr_file || load_ok;
  wire [FILE_AW-1:0] mem_wa = wr_file ? f_addr : LOAD_WR_ADDR;
  wire [DATA_W-1:0] mem_wd = wr_file ? file_res : LOAD_WR_DATA;

  // next working register
  always_comb
  begin
    w_d = w_q;
    if (wr_w_file)
    begin
      w_d = file_res;
    end
    else if (live && is_clear_working)
    begin
      w_d = DATA_ZERO;
    end
    else if (live && is_or_literal_working)
    begin
      w_d = or_val;
    end
  end

  // next zero flag; skip variants leave it alone
  always_comb
  begin
    z_d = z_q;
    if (live && (is_decrement_file || is_increment_file))
    begin
      z_d = file_res_zero;
    end
    else if (live && is_clear_working)
    begin
      z_d = 1'b1;
    end
    else if (live && is_or_literal_working)
    begin
      z_d = or_zero;
    end
  end

  // next program counter
  always_comb
  begin
    pc_d = pc_q;
    if (take_unconditional_branch)
    begin
      pc_d = {PC_UPPER_LATCH[LATCH_HI:LATCH_LO], br_target};
    end
    else if (in_exec)
    begin
      pc_d = pc_q + PC_ONE;
    end
  end

  // discard flag: set by a taken skip or branch, consumed by the next op
  always_comb
  begin
    skip_d = skip_q;
    if (in_exec)
    begin
      skip_d = take_skip || take_unconditional_branch;
    end
  end

  // phase sequencing: every op is one accept plus one execute clock
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  casbe_file_mem u_file_mem (
    .clk(CLOCK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .re(accept),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      instr_q <= INSTR_RESET;
      skip_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      state_q <= state_d;
      skip_q <= skip_d;
      ready_q <= (state_d == ST_IDLE);
      if (accept)
      begin
        instr_q <= INSTR;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      w_q <= W_RESET;
      z_q <= Z_RESET;
      pc_q <= PC_RESET;
    end
    else if (CLK_EN)
    begin
      w_q <= w_d;
      z_q <= z_d;
      pc_q <= pc_d;
    end
  end

  // status pulses and write-back trace
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      done_q <= 1'b0;
      disc_q <= 1'b0;
      fwe_q <= 1'b0;
      fwa_q <= '0;
      fwd_q <= DATA_ZERO;
    end
    else if (CLK_EN)
    begin
      done_q <= in_exec;
      disc_q <= in_exec && skip_q;
      fwe_q <= wr_file;
      fwa_q <= f_addr;
      fwd_q <= file_res;
    end
  end

  assign INSTR_READY = ready_q;
  assign INSTR_DONE = done_q;
  assign INSTR_DISCARDED = disc_q;
  assign WORKING = w_q;
  assign ZERO_FLAG = z_q;
  assign PC = pc_q;
  assign FILE_WR_EN = fwe_q;
  assign FILE_WR_ADDR = fwa_q;
  assign FILE_WR_DATA = fwd_q;

endmodule // casbe_exec

// File: hw/casbe_pkg.sv
// constants and types shared by the arithmetic, skip and branch execution block
package casbe_pkg;

  // widths
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int PC_W = 15;
  localparam int BR_W = 11;
  localparam int LATCH_W = 8;
  localparam int FILE_DEPTH = 128;

  // field positions inside the instruction word
  localparam int FILE_ADDR_HI = 6;
  localparam int FILE_ADDR_LO = 0;
  localparam int DEST_BIT = 7;
  localparam int LIT_HI = 7;
  localparam int LIT_LO = 0;
  localparam int BR_HI = 10;
  localparam int BR_LO = 0;

  // pc_upper_latch bits that feed the upper program counter on a branch
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;

  // destination select values
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // opcode masks and match values
  localparam logic [INSTR_W-1:0] MASK_FILE_OP = 14'h3f00;
  localparam logic [INSTR_W-1:0] MASK_CLEAR_W = 14'h3ffc;
  localparam logic [INSTR_W-1:0] MASK_BRANCH = 14'h3800;
  localparam logic [INSTR_W-1:0] MASK_LITERAL = 14'h3f00;
  localparam logic [INSTR_W-1:0] OPC_DECREMENT_FILE = 14'h0300;
  localparam logic [INSTR_W-1:0] OPC_INCREMENT_FILE = 14'h0a00;
  localparam logic [INSTR_W-1:0] OPC_DECREMENT_SKIP_ZERO = 14'h0b00;
  localparam logic [INSTR_W-1:0] OPC_INCREMENT_SKIP_ZERO = 14'h0f00;
  localparam logic [INSTR_W-1:0] OPC_CLEAR_WORKING = 14'h0100;
  localparam logic [INSTR_W-1:0] OPC_UNCONDITIONAL_BRANCH = 14'h2800;
  localparam logic [INSTR_W-1:0] OPC_OR_LITERAL_WORKING = 14'h3800;

  // constants and reset values
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic Z_RESET = 1'b0;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } casbe_state_e;

endpackage

// File: hw/casbe_file_mem.sv
// file register storage, one write port and one registered read port
`timescale 1ns/10ps
module casbe_file_mem
  import casbe_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [FILE_AW-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  // read port
  input wire logic re,
  input wire logic [FILE_AW-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // array has no reset so it maps onto plain storage
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  // read-before-write when both ports hit one address in a cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata <= DATA_ZERO;
    end
    else if (ce && re)
    begin
      rdata <= mem[raddr];
    end
  end

endmodule // casbe_file_mem

// File: tb/casbe_chk_sva.sv
// port assertions for the execution block
`timescale 1ns/10ps
module casbe_chk
  import casbe_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // instruction side
  input wire logic CLK_EN,
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR,
  input wire logic INSTR_READY,
  input wire logic INSTR_DONE,
  input wire logic INSTR_DISCARDED,
  input wire logic [LATCH_W-1:0] PC_UPPER_LATCH,
  // state
  input wire logic [DATA_W-1:0] WORKING,
  input wire logic ZERO_FLAG,
  input wire logic [PC_W-1:0] PC,
  input wire logic FILE_WR_EN,
  input wire logic [FILE_AW-1:0] FILE_WR_ADDR,
  input wire logic [DATA_W-1:0] FILE_WR_DATA
);
  logic [INSTR_W-1:0] op_q;
  logic skip_q;
  wire acc = CLK_EN && INSTR_READY && INSTR_VALID;
  wire [INSTR_W-1:0] fm = op_q & MASK_FILE_OP;
  wire q_skip = fm == OPC_DECREMENT_SKIP_ZERO || fm == OPC_INCREMENT_SKIP_ZERO;
  wire q_ar = fm == OPC_DECREMENT_FILE || fm == OPC_INCREMENT_FILE;
  wire q_br = (op_q & MASK_BRANCH) == OPC_UNCONDITIONAL_BRANCH;
  wire q_clr = (op_q & MASK_CLEAR_W) == OPC_CLEAR_WORKING;
  wire [DATA_W-1:0] res = op_q[DEST_BIT] ? FILE_WR_DATA : WORKING;
  wire live = INSTR_DONE && !INSTR_DISCARDED;
  wire [3:0] lat = PC_UPPER_LATCH[LATCH_HI:LATCH_LO];
  // op_q still holds the finishing op at its done cycle, so decoding it there is safe
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      skip_q <= 1'b0;
    else if (CLK_EN && INSTR_DONE)
      skip_q <= live && (q_br || (q_skip && res == DATA_ZERO));
    if (acc)
      op_q <= INSTR;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  property p_lat;
    acc |=> !INSTR_READY ##1 (INSTR_DONE && INSTR_READY);
  endproperty
  a_lat: assert property (p_lat) else $error("bad latency");
  property p_disc;
    INSTR_DONE |-> INSTR_DISCARDED == skip_q;
  endproperty
  a_disc: assert property (p_disc) else $error("bad discard");
  property p_clr;
    live && q_clr |-> WORKING == DATA_ZERO && ZERO_FLAG;
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_zero;
    live && q_ar |-> ZERO_FLAG == (res == DATA_ZERO);
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero flag");
  property p_skipz;
    live && q_skip |-> $stable(ZERO_FLAG);
  endproperty
  a_skipz: assert property (p_skipz) else $error("skip moved flag");
  property p_br;
    live && q_br |-> PC == {$past(lat), op_q[BR_HI:BR_LO]};
  endproperty
  a_br: assert property (p_br) else $error("bad branch");
  property p_pc;
    INSTR_DONE && !(live && q_br) |-> PC == $past(PC) + PC_ONE;
  endproperty
  a_pc: assert property (p_pc) else $error("bad pc step");
  property p_wr;
    live && (q_ar || q_skip) |-> FILE_WR_EN == op_q[DEST_BIT]
      && (!FILE_WR_EN || FILE_WR_ADDR == op_q[FILE_ADDR_HI:FILE_ADDR_LO]);
  endproperty
  a_wr: assert property (p_wr) else $error("bad destination");
endmodule // casbe_chk

bind casbe_exec casbe_chk i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY),
  .INSTR_DONE(INSTR_DONE), .INSTR_DISCARDED(INSTR_DISCARDED),
  .PC_UPPER_LATCH(PC_UPPER_LATCH), .WORKING(WORKING), .ZERO_FLAG(ZERO_FLAG), .PC(PC),
  .FILE_WR_EN(FILE_WR_EN), .FILE_WR_ADDR(FILE_WR_ADDR), .FILE_WR_DATA(FILE_WR_DATA));

// File: tb/casbe_exec_bench.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
module casbe_exec_bench
  import casbe_pkg::*;
;
  logic CLOCK, RST_N, CLK_EN, INSTR_VALID, LOAD_WR_EN;
  logic [INSTR_W-1:0] INSTR;
  logic [LATCH_W-1:0] PC_UPPER_LATCH;
  logic [FILE_AW-1:0] LOAD_WR_ADDR, FILE_WR_ADDR;
  logic [DATA_W-1:0] LOAD_WR_DATA, WORKING, FILE_WR_DATA;
  logic INSTR_READY, INSTR_DONE, INSTR_DISCARDED, ZERO_FLAG, FILE_WR_EN;
  logic [PC_W-1:0] PC, pc_exp;
  int bad_count, n_checks, cyc;
  casbe_exec i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY),
    .INSTR_DONE(INSTR_DONE), .INSTR_DISCARDED(INSTR_DISCARDED),
    .PC_UPPER_LATCH(PC_UPPER_LATCH), .LOAD_WR_EN(LOAD_WR_EN), .LOAD_WR_ADDR(LOAD_WR_ADDR),
    .LOAD_WR_DATA(LOAD_WR_DATA), .WORKING(WORKING), .ZERO_FLAG(ZERO_FLAG), .PC(PC),
    .FILE_WR_EN(FILE_WR_EN), .FILE_WR_ADDR(FILE_WR_ADDR), .FILE_WR_DATA(FILE_WR_DATA));
  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  task automatic end_sim();
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // wide enough for the largest packed compare (write trace plus flag is 17 bits)
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge CLOCK);
    #1;
  endtask
  function automatic logic [INSTR_W-1:0] fop(input logic [INSTR_W-1:0] o, input logic d,
    input logic [FILE_AW-1:0] f);
    fop = o | {6'h00, d, f};
  endfunction
  // a tick first keeps back-to-back preloads from touching the enable twice in one step
  task automatic load(input logic [FILE_AW-1:0] a, input logic [DATA_W-1:0] d);
    tick();
    LOAD_WR_EN = 1'b1;
    LOAD_WR_ADDR = a;
    LOAD_WR_DATA = d;
    tick();
    LOAD_WR_EN = 1'b0;
  endtask
  task automatic run(input logic [INSTR_W-1:0] op, input logic disc);
    int n;
    n = 0;
    while (INSTR_READY !== 1'b1 && n < 9)
    begin
      tick();
      n++;
    end
    INSTR_VALID = 1'b1;
    INSTR = op;
    tick();
    INSTR_VALID = 1'b0;
    tick();
    pc_exp = pc_exp + PC_ONE;
    if (!disc && (op & MASK_BRANCH) == OPC_UNCONDITIONAL_BRANCH)
      pc_exp = {PC_UPPER_LATCH[LATCH_HI:LATCH_LO], op[BR_HI:BR_LO]};
    chk(INSTR_DONE, 1'b1);
    chk(INSTR_DISCARDED, disc);
    chk(PC, pc_exp);
  endtask
  task automatic t_dec();
    load(7'h10, 8'h01);
    load(7'h11, 8'h00);
    run(fop(OPC_DECREMENT_FILE, 1'b1, 7'h10), 1'b0);
    chk({FILE_WR_EN, FILE_WR_ADDR, FILE_WR_DATA, ZERO_FLAG}, {1'b1, 7'h10, 8'h00, 1'b1});
    run(fop(OPC_DECREMENT_FILE, 1'b0, 7'h11), 1'b0);
    chk({FILE_WR_EN, WORKING, ZERO_FLAG}, {1'b0, 8'hff, 1'b0});
    run(fop(OPC_DECREMENT_FILE, 1'b0, 7'h10), 1'b0);
    chk(WORKING, 8'hff);
  endtask
  task automatic t_inc();
    load(7'h7f, 8'hff);
    run(fop(OPC_INCREMENT_FILE, 1'b0, 7'h7f), 1'b0);
    chk({WORKING, ZERO_FLAG}, {8'h00, 1'b1});
    run(fop(OPC_INCREMENT_FILE, 1'b1, 7'h7f), 1'b0);
    chk({FILE_WR_DATA, WORKING}, {8'h00, 8'h00});
  endtask
  task automatic t_lit();
    run(OPC_OR_LITERAL_WORKING | 14'h005a, 1'b0);
    run(OPC_OR_LITERAL_WORKING | 14'h0081, 1'b0);
    chk({WORKING, ZERO_FLAG}, {8'hdb, 1'b0});
    run(OPC_CLEAR_WORKING, 1'b0);
    chk({WORKING, ZERO_FLAG}, {8'h00, 1'b1});
    run(OPC_OR_LITERAL_WORKING, 1'b0);
    chk({WORKING, ZERO_FLAG}, {8'h00, 1'b1});
    run(OPC_OR_LITERAL_WORKING | 14'h00a5, 1'b0);
  endtask
  task automatic t_skip();
    load(7'h20, 8'h01);
    load(7'h21, 8'hff);
    load(7'h22, 8'h05);
    run(fop(OPC_DECREMENT_SKIP_ZERO, 1'b1, 7'h20), 1'b0);
    chk({FILE_WR_DATA, ZERO_FLAG}, {8'h00, 1'b0});
    run(OPC_CLEAR_WORKING, 1'b1);
    chk(WORKING, 8'ha5);
    run(fop(OPC_INCREMENT_SKIP_ZERO, 1'b0, 7'h21), 1'b0);
    chk({WORKING, ZERO_FLAG}, {8'h00, 1'b0});
    run(fop(OPC_DECREMENT_SKIP_ZERO, 1'b0, 7'h22), 1'b1);
    run(fop(OPC_DECREMENT_SKIP_ZERO, 1'b0, 7'h22), 1'b0);
    chk(WORKING, 8'h04);
    run(OPC_CLEAR_WORKING, 1'b0);
  endtask
  task automatic t_branch();
    PC_UPPER_LATCH = 8'h78;
    run(OPC_UNCONDITIONAL_BRANCH | 14'h07ff, 1'b0);
    run(fop(OPC_INCREMENT_FILE, 1'b0, 7'h7f), 1'b1);
    chk(WORKING, 8'h00);
    PC_UPPER_LATCH = 8'h87;
    run(OPC_UNCONDITIONAL_BRANCH | 14'h0001, 1'b0);
    run(OPC_UNCONDITIONAL_BRANCH | 14'h0555, 1'b1);
    run(OPC_OR_LITERAL_WORKING, 1'b0);
  endtask
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    {RST_N, INSTR_VALID, LOAD_WR_EN, LOAD_WR_ADDR, LOAD_WR_DATA} = '0;
    {INSTR, PC_UPPER_LATCH, pc_exp} = '0;
    CLK_EN = 1'b1;
    repeat (12) @(posedge CLOCK);
    #1;
    RST_N = 1'b1;
    t_dec();
    t_inc();
    t_lit();
    t_skip();
    t_branch();
    end_sim();
  end
endmodule // casbe_exec_bench
